// ==== pkg/pci_host_irq_latency_pkg.sv ====
// constants, types and helpers shared by the bus interface support logic
package pci_host_irq_latency_pkg;

   // register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [11:0] OFF_CFG = 12'h000;
   localparam logic [11:0] OFF_PENDING = 12'h004;
   localparam logic [11:0] OFF_MASK = 12'h008;
   localparam logic [11:0] OFF_HOLD = 12'h00C;
   localparam logic [11:0] OFF_STATE = 12'h010;

   // field positions
   localparam int CFG_BYTE_ORDER_BIT = 0;
   localparam int IRQ_XFER_DONE_BIT = 0;
   localparam int IRQ_PREEMPT_BIT = 1;
   localparam int STATE_OWNER_BIT = 8;

   // widths
   localparam int IRQ_W = 8;
   localparam int EXT_IRQ_W = 6;
   localparam int HOLD_W = 8;

   // reset values
   localparam logic CFG_RESET = 1'b0;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;

   // master ownership states
   typedef enum logic {BUS_IDLE, BUS_OWNED} bus_state_t;

   // reverse the four byte lanes of a word
   function automatic logic [31:0] swap_bytes(input logic [31:0] w);
      swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

endpackage

// ==== pkg/hold_ctrl_if.sv ====
// control and status wires between the ownership sequencer and its counter
`timescale 1ns/1ps
`default_nettype none
interface hold_ctrl_if #(parameter int W = 8);
   logic load;
   logic dec;
   logic [W-1:0] loadValue;
   logic [W-1:0] count;
   modport ctrl (output load, output dec, output loadValue, input count);
   modport cnt (input load, input dec, input loadValue, output count);
endinterface
`default_nettype wire

// ==== src/hold_counter.sv ====
// down-counter that times how long bus ownership is kept
`timescale 1ns/1ps
`default_nettype none
module hold_counter
   import pci_host_irq_latency_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // sequencer side
   hold_ctrl_if.cnt hc
);

   // load wins over decrement; stops at zero instead of wrapping
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         hc.count <= HOLD_RESET;
      end
      else if (hc.load)
      begin
         hc.count <= hc.loadValue;
      end
      else if (hc.dec && (hc.count != HOLD_RESET))
      begin
         hc.count <= hc.count - 8'h01;
      end
   end

endmodule
`default_nettype wire

// ==== src/byte_order_swap.sv ====
// registered byte lane steering for one fifo data direction
`timescale 1ns/1ps
`default_nettype none
module byte_order_swap
   import pci_host_irq_latency_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // control
   input wire logic swapEn,
   // data
   input wire logic [31:0] inData,
   output logic [31:0] outData
);

   // one register stage keeps the top outputs straight from a flop
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         outData <= DATA_RESET;
      end
      else
      begin
         outData <= swapEn ? swap_bytes(inData) : inData;
      end
   end

endmodule
`default_nettype wire

// ==== src/pci_host_irq_latency.sv ====
// bus interface support: fifo byte order, interrupt pin and ownership timer
//
// Notes on behaviour
// - config bit 0 picks fifo byte order: 0 little endian, 1 big endian.
// - after reset the byte order is little endian until software sets it.
// - byte order affects only transmit and receive fifo data, not registers.
// - register accesses map bus line n to register bit n, always.
// - interrupt is signalled by pulling the open-drain pin low.
// - one sticky pending bit per source; several may be set together.
// - reading the pending register returns it and clears all its bits.
// - a mask register suppresses the interrupt pin for chosen sources.
// - the programmed hold value is the least number of clocks bus is kept, unless transfer ends first.
// - the hold counter counts down once bus is gained and frame asserted.
// - on grant loss keep bus until counter is zero or transfer ends.
// - the hold counter is an 8-bit down-counter.
`timescale 1ns/1ps
`default_nettype none
module pci_host_irq_latency
   import pci_host_irq_latency_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // apb register slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fifo data paths
   input wire logic [31:0] txFifoData,
   output logic [31:0] txBusData,
   input wire logic [31:0] busRxData,
   output logic [31:0] rxFifoData,
   // interrupt sources and open-drain pin
   input wire logic [5:0] extIrq,
   output logic irqOutN,
   output logic irqOeN,
   // bus master ownership
   input wire logic masterReq,
   input wire logic transferDone,
   input wire logic grantInN,
   output logic frameOutN,
   output logic busOwner
);

   logic byteOrderSelect_reg;
   logic [7:0] irqPending_reg;
   logic [7:0] irqPending_next;
   logic [7:0] irqMask_reg;
   logic [7:0] masterHoldCount_reg;
   logic [7:0] irqSet;
   logic [7:0] irqClr;
   logic [31:0] readMux;
   logic mapped;
   logic apbWrite;
   logic apbCapture;
   logic pendingRead;
   logic anyIrq;
   logic holdZero;
   logic doneEv;
   logic preemptEv;
   logic startEv;
   bus_state_t state_reg;
   bus_state_t state_next;

   hold_ctrl_if #(.W(HOLD_W)) hc ();

   // bus phase decode; one wait state gives time to capture read data
   assign apbCapture = psel && penable && !pready;
   assign apbWrite = psel && penable && pready && pwrite;
   assign pendingRead = apbCapture && !pwrite && (paddr == OFF_PENDING);

   // address decode for the defined answer to unmapped offsets
   always_comb
   begin
      mapped = 1'b1;
      unique case (paddr)
         OFF_CFG, OFF_PENDING, OFF_MASK, OFF_HOLD, OFF_STATE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // read mux, every line straight onto the same bit; no byte steering
   always_comb
   begin
      readMux = DATA_RESET;
      unique case (paddr)
         OFF_CFG: readMux[CFG_BYTE_ORDER_BIT] = byteOrderSelect_reg;
         OFF_PENDING: readMux[7:0] = irqPending_reg;
         OFF_MASK: readMux[7:0] = irqMask_reg;
         OFF_HOLD: readMux[7:0] = masterHoldCount_reg;
         OFF_STATE:
         begin
            readMux[7:0] = hc.count;
            readMux[STATE_OWNER_BIT] = (state_reg == BUS_OWNED);
         end
         default: readMux = DATA_RESET;
      endcase
   end

   // apb handshake: ready and error raised in the cycle after capture
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= apbCapture;
         pslverr <= apbCapture && !mapped;
      end
   end

   // read data held from a read capture until the next read capture
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata <= DATA_RESET;
      end
      else if (apbCapture && !pwrite)
      begin
         prdata <= readMux;
      end
   end

   // software controls; byte order starts little endian
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         byteOrderSelect_reg <= CFG_RESET;
         irqMask_reg <= MASK_RESET;
         masterHoldCount_reg <= HOLD_RESET;
      end
      else if (apbWrite)
      begin
         if (paddr == OFF_CFG)
         begin
            byteOrderSelect_reg <= pwdata[CFG_BYTE_ORDER_BIT];
         end
         if (paddr == OFF_MASK)
         begin
            irqMask_reg <= pwdata[7:0];
         end
         if (paddr == OFF_HOLD)
         begin
            masterHoldCount_reg <= pwdata[7:0];
         end
      end
   end

   // fifo data lanes follow the byte order; registers never pass here
   byte_order_swap u_txSwap (
      .mclk(mclk),
      .resetn(resetn),
      .swapEn(byteOrderSelect_reg),
      .inData(txFifoData),
      .outData(txBusData)
   );

   byte_order_swap u_rxSwap (
      .mclk(mclk),
      .resetn(resetn),
      .swapEn(byteOrderSelect_reg),
      .inData(busRxData),
      .outData(rxFifoData)
   );

   // pending bits: a set in the clearing cycle survives the clear
   assign irqSet = {extIrq, preemptEv, doneEv};
   always_comb
   begin
      irqClr = 8'h00;
      if (pendingRead)
      begin
         irqClr = 8'hFF;
      end
      else if (apbWrite && (paddr == OFF_PENDING))
      begin
         irqClr = pwdata[7:0];
      end
      irqPending_next = (irqPending_reg & ~irqClr) | irqSet;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         irqPending_reg <= 8'h00;
      end
      else
      begin
         irqPending_reg <= irqPending_next;
      end
   end

   // open-drain pin: level always low, enable low pulls the wire down
   assign anyIrq = |(irqPending_reg & irqMask_reg);
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         irqOutN <= 1'b0;
         irqOeN <= 1'b1;
      end
      else
      begin
         irqOutN <= 1'b0;
         irqOeN <= !anyIrq;
      end
   end

   // ownership sequencer; frame and owner pins are registered from the next state, so they change with the state
   assign holdZero = (hc.count == HOLD_RESET);
   always_comb
   begin
      state_next = state_reg;
      startEv = 1'b0;
      doneEv = 1'b0;
      preemptEv = 1'b0;
      unique case (state_reg)
         BUS_IDLE:
         begin
            if (masterReq && !grantInN)
            begin
               startEv = 1'b1;
               state_next = BUS_OWNED;
            end
         end
         BUS_OWNED:
         begin
            if (transferDone)
            begin
               doneEv = 1'b1;
               state_next = BUS_IDLE;
            end
            else if (grantInN && holdZero)
            begin
               preemptEv = 1'b1;
               state_next = BUS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= BUS_IDLE;
         frameOutN <= 1'b1;
         busOwner <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         frameOutN <= (state_next != BUS_OWNED);
         busOwner <= (state_next == BUS_OWNED);
      end
   end

   // counter loaded with frame, then counts while owned
   assign hc.load = startEv;
   assign hc.loadValue = masterHoldCount_reg;
   assign hc.dec = (state_reg == BUS_OWNED);

   hold_counter u_holdCounter (
      .mclk(mclk),
      .resetn(resetn),
      .hc(hc)
   );

   // checks on the block's outputs and on its internal state
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   property p_swap_order;
      byteOrderSelect_reg |=> (rxFifoData == swap_bytes($past(busRxData)));
   endproperty
   a_swap_order: assert property (p_swap_order)
      else $error("big endian rx lanes not reversed");

   property p_little_default;
      !byteOrderSelect_reg |=> (txBusData == $past(txFifoData));
   endproperty
   a_little_default: assert property (p_little_default)
      else $error("little endian tx lanes altered");

   property p_reg_aligned;
      (pready && psel && !pwrite && (paddr == OFF_MASK))
         |-> (prdata[7:0] == irqMask_reg);
   endproperty
   a_reg_aligned: assert property (p_reg_aligned)
      else $error("register read not bit aligned");

   property p_read_clears;
      pendingRead |=> (irqPending_reg == $past(irqSet));
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("pending read did not clear bits");

   property p_sticky;
      (!pendingRead && !(apbWrite && (paddr == OFF_PENDING)))
         |=> ((irqPending_reg & $past(irqPending_reg))
              == $past(irqPending_reg));
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("pending bit lost without clear");

   property p_pin_low;
      (anyIrq ##1 anyIrq) |-> (!irqOeN && !irqOutN);
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("interrupt pin not pulled low");

   property p_mask_off;
      (irqMask_reg == 8'h00) [*2] |-> irqOeN;
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("masked interrupt reached pin");

   property p_start_load;
      (state_reg == BUS_IDLE && masterReq && !grantInN)
         |=> (!frameOutN && busOwner
              && (hc.count == $past(masterHoldCount_reg)));
   endproperty
   a_start_load: assert property (p_start_load)
      else $error("frame start did not load counter");

   property p_hold_min;
      (state_reg == BUS_OWNED && !transferDone && !holdZero)
         |=> (state_reg == BUS_OWNED && !frameOutN);
   endproperty
   a_hold_min: assert property (p_hold_min)
      else $error("bus released before hold count expired");

   property p_countdown;
      (state_reg == BUS_OWNED && !holdZero)
         |=> (hc.count == $past(hc.count) - 8'h01);
   endproperty
   a_countdown: assert property (p_countdown)
      else $error("hold counter did not step down by one");

   property p_done_release;
      (state_reg == BUS_OWNED && transferDone)
         |=> (frameOutN && !busOwner && irqPending_reg[IRQ_XFER_DONE_BIT]);
   endproperty
   a_done_release: assert property (p_done_release)
      else $error("transfer end did not release bus");

   c_preempt: cover property (preemptEv);
   c_done: cover property (doneEv);
   c_read_clear: cover property (pendingRead && (irqPending_reg != 8'h00));
   c_big_endian: cover property (byteOrderSelect_reg ##1 byteOrderSelect_reg);

endmodule
`default_nettype wire

// ==== test/pci_arbiter_model.sv ====
// behavioural host bridge and arbiter facing the device's bus pins
`timescale 1ns/1ps
`default_nettype none
module pci_arbiter_model
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // bench control
   input wire logic grantAllow,
   // device side
   input wire logic masterReq,
   input wire logic irqOutN,
   input wire logic irqOeN,
   output logic grantInN,
   output logic intLine
);
   // grant follows the request; withdrawal may land mid-transfer
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         grantInN <= 1'b1;
      else
         grantInN <= !(masterReq && grantAllow);
   end
   // host pull-up: a released pin reads high, never the last driven value
   assign intLine = irqOeN ? 1'b1 : irqOutN;
endmodule
`default_nettype wire

// ==== test/pci_host_irq_latency_tb.sv ====
// self-checking bench for the bus interface support block
`timescale 1ns/1ps
`default_nettype none
module pci_host_irq_latency_tb
   import pci_host_irq_latency_pkg::*;
;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata, txFifoData, txBusData;
   logic [31:0] busRxData, rxFifoData;
   logic [5:0] extIrq;
   logic irqOutN, irqOeN, masterReq, transferDone, grantInN;
   logic frameOutN, busOwner, grantAllow, intLine;
   int badCount, comparisons;

   pci_host_irq_latency dut_u (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .txFifoData(txFifoData), .txBusData(txBusData),
      .busRxData(busRxData), .rxFifoData(rxFifoData), .extIrq(extIrq),
      .irqOutN(irqOutN), .irqOeN(irqOeN), .masterReq(masterReq),
      .transferDone(transferDone), .grantInN(grantInN),
      .frameOutN(frameOutN), .busOwner(busOwner));

   pci_arbiter_model arb_u (.mclk(mclk), .resetn(resetn),
      .grantAllow(grantAllow), .masterReq(masterReq), .irqOutN(irqOutN),
      .irqOeN(irqOeN), .grantInN(grantInN), .intLine(intLine));

   // free-running 25 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task conclude;
      $display("counts: %0d compared, %0d mismatched", comparisons, badCount);
      if (badCount == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task check(input string what, input logic [31:0] exp,
              input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         badCount++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one apb transfer; the wait for pready is bounded
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         badCount++;
         conclude();
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      check(what, exp, rdata);
   endtask

   // fifo words appear on the far side one cycle after capture
   task lanes(input logic [31:0] expTx, input logic [31:0] expRx);
      @(posedge mclk);
      txFifoData <= 32'h1122_3344;
      busRxData <= 32'hA1B2_C3D4;
      tick(2);
      check("tx lanes", expTx, txBusData);
      check("rx lanes", expRx, rxFifoData);
   endtask

   task irqPulse(input logic [5:0] v);
      @(posedge mclk);
      extIrq <= v;
      @(posedge mclk);
      extIrq <= 6'h00;
      tick(2);
   endtask

   // gain the bus, drop request and grant at once, count owned cycles
   task own(input logic [7:0] hold, input int doneAt, input int exp);
      int n;
      wr(OFF_HOLD, {24'h00_0000, hold});
      @(posedge mclk);
      masterReq <= 1'b1;
      grantAllow <= 1'b1;
      n = 0;
      while (busOwner !== 1'b1 && n < 10)
      begin
         @(posedge mclk);
         n++;
      end
      // a grant that never comes ends the run instead of a silent miss
      if (busOwner !== 1'b1)
      begin
         badCount++;
         conclude();
      end
      check("frame low", 32'h0000_0000, {31'h0, frameOutN});
      masterReq <= 1'b0;
      grantAllow <= 1'b0;
      n = 1;
      repeat (300)
      begin
         @(posedge mclk);
         if (busOwner !== 1'b1)
            break;
         n++;
         transferDone <= (n == doneAt);
      end
      transferDone <= 1'b0;
      // bus never released within the bound counts as a hang
      if (n > 300)
      begin
         badCount++;
         conclude();
      end
      check("owned cycles", exp, n);
      check("frame released", 32'h0000_0001, {31'h0, frameOutN});
   endtask

   // main sequence
   initial
   begin
      badCount = 0;
      comparisons = 0;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      txFifoData = 32'h0000_0000;
      busRxData = 32'h0000_0000;
      extIrq = 6'h00;
      masterReq = 1'b0;
      transferDone = 1'b0;
      grantAllow = 1'b0;
      tick(8);
      resetn <= 1'b1;
      lanes(32'h1122_3344, 32'hA1B2_C3D4);
      rd(OFF_CFG, 32'h0000_0000, "cfg reset");
      rd(OFF_MASK, 32'h0000_0000, "mask reset");
      check("pin idle", 32'h0000_0001, {31'h0, intLine});
      wr(OFF_CFG, 32'h0000_0001);
      rd(OFF_CFG, 32'h0000_0001, "cfg set");
      lanes(32'h4433_2211, 32'hD4C3_B2A1);
      wr(OFF_HOLD, 32'hFFFF_FFA5);
      rd(OFF_HOLD, 32'h0000_00A5, "hold bits");
      apb(1'b0, 12'h020, 32'h0000_0000);
      check("unmapped err", 32'h0000_0001, {31'h0, rerr});
      check("unmapped data", 32'h0000_0000, rdata);
      wr(OFF_CFG, 32'h0000_0000);
      lanes(32'h1122_3344, 32'hA1B2_C3D4);
      $display("test byte order done");
      wr(OFF_MASK, 32'h0000_00FC);
      irqPulse(6'b00_0101);
      check("pin asserted", 32'h0000_0000, {31'h0, intLine});
      rd(OFF_PENDING, 32'h0000_0014, "pending two");
      rd(OFF_PENDING, 32'h0000_0000, "pending cleared");
      check("pin released", 32'h0000_0001, {31'h0, intLine});
      wr(OFF_MASK, 32'h0000_0000);
      irqPulse(6'b10_0000);
      check("pin masked", 32'h0000_0001, {31'h0, intLine});
      wr(OFF_MASK, 32'h0000_0080);
      tick(2);
      check("pin unmasked", 32'h0000_0000, {31'h0, intLine});
      rd(OFF_PENDING, 32'h0000_0080, "pending masked");
      // writing a one clears only that pending bit
      irqPulse(6'b00_0011);
      wr(OFF_PENDING, 32'h0000_0004);
      rd(OFF_PENDING, 32'h0000_0008, "write one clear");
      $display("test interrupt done");
      own(8'h03, 0, 4);
      rd(OFF_PENDING, 32'h0000_0002, "preempt event");
      own(8'hFF, 0, 256);
      rd(OFF_PENDING, 32'h0000_0002, "preempt full");
      own(8'h32, 4, 5);
      rd(OFF_PENDING, 32'h0000_0001, "done event");
      // 50 loaded, five owned cycles stepped it down, not owned any more
      rd(OFF_STATE, 32'h0000_002D, "state count");
      $display("test ownership done");
      conclude();
   end
endmodule
`default_nettype wire
